// ---- rtl/hmc_map.svh ----
`ifndef HMC_MAP_SVH
`define HMC_MAP_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define HMC_CLK_MHZ              100

// ----------------------------------------------------------------------------
// Data layout
// ----------------------------------------------------------------------------
`define HMC_DATA_W               12
`define HMC_NCHAN                4
`define HMC_CH_X                 2'h0
`define HMC_CH_Y                 2'h1
`define HMC_CH_Z                 2'h2
`define HMC_CH_T                 2'h3
`define HMC_TMR_W                16
`define HMC_LP_W                 24
`define HMC_INT_W                9

// ----------------------------------------------------------------------------
// End-of-conversion pulse, ns
// ----------------------------------------------------------------------------
`define HMC_T_INT_MIN_NS         1800
`define HMC_T_INT_TYP_NS         2500
`define HMC_T_INT_MAX_NS         3200
`define HMC_INT_CYC              ((`HMC_T_INT_TYP_NS * `HMC_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------------
// Read windows, us; the host reads at half the least window
// ----------------------------------------------------------------------------
`define HMC_T_RD1_FULL_MIN_US    30
`define HMC_T_RD1_FULL_MAX_US    50
`define HMC_T_RD1_SR_MIN_US      42
`define HMC_T_RD1_SR_MAX_US      70
`define HMC_T_RDN_FULL_MIN_US    32
`define HMC_T_RDN_FULL_MAX_US    54
`define HMC_T_RDN_SR_MIN_US      44
`define HMC_T_RDN_SR_MAX_US      74
`define HMC_RD1_FULL_CYC         ((`HMC_T_RD1_FULL_MIN_US * `HMC_CLK_MHZ) / 2)
`define HMC_RD1_SR_CYC           ((`HMC_T_RD1_SR_MIN_US * `HMC_CLK_MHZ) / 2)
`define HMC_RDN_FULL_CYC         ((`HMC_T_RDN_FULL_MIN_US * `HMC_CLK_MHZ) / 2)
`define HMC_RDN_SR_CYC           ((`HMC_T_RDN_SR_MIN_US * `HMC_CLK_MHZ) / 2)

// ----------------------------------------------------------------------------
// Conversion time per channel, us
// ----------------------------------------------------------------------------
`define HMC_T_CONV_FULL_US       43
`define HMC_T_CONV_SR_US         59
`define HMC_CONV_FULL_CYC        (`HMC_T_CONV_FULL_US * `HMC_CLK_MHZ)
`define HMC_CONV_SR_CYC          (`HMC_T_CONV_SR_US * `HMC_CLK_MHZ)

// ----------------------------------------------------------------------------
// Low-power update rates, Hz
// ----------------------------------------------------------------------------
`define HMC_LP_SLOW_HZ           10
`define HMC_LP_FAST_HZ           160
`define HMC_LP_SLOW_CYC          ((`HMC_CLK_MHZ * 1000000) / `HMC_LP_SLOW_HZ)
`define HMC_LP_FAST_CYC          ((`HMC_CLK_MHZ * 1000000) / `HMC_LP_FAST_HZ)

// ----------------------------------------------------------------------------
// Serial bus, kHz; one read takes one clock
// ----------------------------------------------------------------------------
`define HMC_BUS_MIN_KHZ          800

`endif

// ---- rtl/hmc_pkg.sv ----
package hmc_pkg;

    typedef enum logic [1:0] {
        HMC_POWER_DOWN,
        HMC_LOW_POWER,
        HMC_FAST,
        HMC_MASTER
    } hmc_mode_e;

    typedef enum logic [1:0] {
        HMC_CFG_XYZT,
        HMC_CFG_XYZ,
        HMC_CFG_XY
    } hmc_chcfg_e;

    typedef enum {
        HMC_DS_IDLE,
        HMC_DS_CONV
    } hmc_dev_state_e;

    typedef enum {
        HMC_HS_IDLE,
        HMC_HS_WAIT,
        HMC_HS_READ,
        HMC_HS_DATA
    } hmc_host_state_e;

    typedef logic [11:0] hmc_sample_t;

endpackage

// ---- rtl/hmc_link_if.sv ----
`timescale 1ns/1ps
interface hmc_link_if;
    logic                 int_n;
    logic                 trig;
    logic                 rd_req;
    logic                 rd_valid;
    hmc_pkg::hmc_sample_t rd_data;
    logic [1:0]           rd_chan;

    modport dev (
        output int_n,
        output rd_valid,
        output rd_data,
        output rd_chan,
        input  trig,
        input  rd_req
    );

    modport host (
        input  int_n,
        input  rd_valid,
        input  rd_data,
        input  rd_chan,
        output trig,
        output rd_req
    );
endinterface

// ---- rtl/hmc_delay.sv ----
`timescale 1ns/1ps
`include "hmc_map.svh"
module hmc_delay (
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  start_i,
    input  wire logic [`HMC_TMR_W-1:0] load_i,
    output logic                       done_o,
    output logic                       busy_o
);
    typedef struct packed {
        logic                  busy;
        logic                  done;
        logic [`HMC_TMR_W-1:0] cnt;
    } hmc_delay_s;

    hmc_delay_s dly_reg;
    hmc_delay_s dly_next;

    // ------------------------------------------------------------------------
    // Down counter, one-cycle done pulse; a start restarts it
    // ------------------------------------------------------------------------
    always_comb begin
        dly_next      = dly_reg;
        dly_next.done = 1'b0;
        if (start_i) begin
            dly_next.busy = 1'b1;
            dly_next.cnt  = load_i;
        end else if (dly_reg.busy) begin
            if (dly_reg.cnt <= `HMC_TMR_W'(1)) begin
                dly_next.busy = 1'b0;
                dly_next.done = 1'b1;
            end else begin
                dly_next.cnt = dly_reg.cnt - `HMC_TMR_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dly_reg <= '0;
        end else begin
            dly_reg <= dly_next;
        end
    end

    assign done_o = dly_reg.done;
    assign busy_o = dly_reg.busy;
endmodule

// ---- rtl/hmc_device.sv ----
// Behaviour
// - Pulse interrupt low about 2.5 us
// - Host reads first full-range result in time
// - Host reads first short-range result in time
// - Host spaces full-range reads within window
// - Host spaces short-range reads within window
// - Host syncs reads to cycles in fast mode
// - Fast mode restarts cycle at once
// - Other modes start only on trigger
// - Four channels: cycle ends after temperature
// - Three channels: no temperature, end after vertical
// - Two axes: vertical and temperature untouched
// - Fast mode host: fast bus, interrupt timing
// - Temperature enabled after reset, can disable
// - Low power cycles at 10 or 160 Hz
`timescale 1ns/1ps
`include "hmc_map.svh"
module hmc_device #(
    parameter int CONV_FULL_CYC = `HMC_CONV_FULL_CYC,
    parameter int CONV_SR_CYC   = `HMC_CONV_SR_CYC,
    parameter int LP_SLOW_CYC   = `HMC_LP_SLOW_CYC,
    parameter int LP_FAST_CYC   = `HMC_LP_FAST_CYC
) (
    input  wire logic                                  ref_clk_i,
    input  wire logic                                  resetn_i,
    hmc_link_if.dev                                    link,
    input  wire hmc_pkg::hmc_mode_e                    mode_i,
    input  wire hmc_pkg::hmc_chcfg_e                   chan_cfg_i,
    input  wire logic                                  range_short_i,
    input  wire logic                                  int_en_i,
    input  wire logic                                  lp_rate_fast_i,
    input  wire logic [`HMC_NCHAN-1:0][`HMC_DATA_W-1:0] sample_i,
    output logic [`HMC_NCHAN-1:0][`HMC_DATA_W-1:0]      result_o,
    output logic                                       busy_o,
    output logic                                       cycle_done_o,
    output logic [1:0]                                 chan_o
);
    typedef struct packed {
        hmc_pkg::hmc_dev_state_e                 state;
        hmc_pkg::hmc_chcfg_e                     cfg;
        logic                                    short_rng;
        logic [1:0]                              chan;
        logic                                    trig_pend;
        logic [`HMC_LP_W-1:0]                    lp_cnt;
        logic [`HMC_INT_W-1:0]                   int_cnt;
        logic                                    int_n;
        logic                                    done;
        logic [`HMC_NCHAN-1:0][`HMC_DATA_W-1:0]  res;
        logic [1:0]                              rd_ptr;
        logic                                    rd_valid;
        logic [`HMC_DATA_W-1:0]                  rd_data;
        logic [1:0]                              rd_chan;
    } hmc_dev_s;

    hmc_dev_s              dev_reg;
    hmc_dev_s              dev_next;
    logic                  tmr_start;
    logic [`HMC_TMR_W-1:0] tmr_load;
    logic                  tmr_done;
    logic                  lp_tick;
    logic                  trig_now;
    logic                  start_cycle;
    logic                  start_short;

    // ------------------------------------------------------------------------
    // Last channel of a configuration
    // ------------------------------------------------------------------------
    function automatic logic [1:0] last_chan(input hmc_pkg::hmc_chcfg_e cfg);
        case (cfg)
            hmc_pkg::HMC_CFG_XYZ: last_chan = `HMC_CH_Z;
            hmc_pkg::HMC_CFG_XY:  last_chan = `HMC_CH_Y;
            default:              last_chan = `HMC_CH_T;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Conversion timer
    // ------------------------------------------------------------------------
    hmc_delay u_conv_tmr (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .start_i   (tmr_start),
        .load_i    (tmr_load),
        .done_o    (tmr_done),
        .busy_o    ()
    );

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        dev_next          = dev_reg;
        dev_next.done     = 1'b0;
        dev_next.rd_valid = 1'b0;
        tmr_start         = 1'b0;
        start_cycle       = 1'b0;
        start_short       = dev_reg.short_rng;
        lp_tick           = 1'b0;

        // Internal trigger source for low-power mode
        if (mode_i == hmc_pkg::HMC_LOW_POWER) begin
            if (dev_reg.lp_cnt == '0) begin
                lp_tick         = 1'b1;
                dev_next.lp_cnt = lp_rate_fast_i ? `HMC_LP_W'(LP_FAST_CYC - 1)
                                                 : `HMC_LP_W'(LP_SLOW_CYC - 1);
            end else begin
                dev_next.lp_cnt = dev_reg.lp_cnt - `HMC_LP_W'(1);
            end
        end else begin
            dev_next.lp_cnt = '0;
        end

        trig_now = (mode_i == hmc_pkg::HMC_MASTER && link.trig) ||
                   (mode_i == hmc_pkg::HMC_LOW_POWER && lp_tick);

        case (dev_reg.state)
            hmc_pkg::HMC_DS_IDLE: begin
                if (mode_i == hmc_pkg::HMC_FAST || trig_now || dev_reg.trig_pend) begin
                    start_cycle = 1'b1;
                end
                dev_next.trig_pend = 1'b0;
            end
            hmc_pkg::HMC_DS_CONV: begin
                if (tmr_done) begin
                    dev_next.res[dev_reg.chan] = sample_i[dev_reg.chan];
                    if (dev_reg.chan == last_chan(dev_reg.cfg)) begin
                        dev_next.done   = 1'b1;
                        dev_next.rd_ptr = `HMC_CH_X;
                        dev_next.state  = hmc_pkg::HMC_DS_IDLE;
                        if (int_en_i) begin
                            dev_next.int_n   = 1'b0;
                            dev_next.int_cnt = `HMC_INT_W'(`HMC_INT_CYC);
                        end
                        if (mode_i == hmc_pkg::HMC_FAST) begin
                            start_cycle = 1'b1;
                        end else if (dev_reg.trig_pend || trig_now) begin
                            start_cycle = 1'b1;
                        end
                        dev_next.trig_pend = 1'b0;
                    end else begin
                        dev_next.chan = dev_reg.chan + 2'h1;
                        tmr_start     = 1'b1;
                        if (trig_now) begin
                            dev_next.trig_pend = 1'b1;
                        end
                    end
                end else if (trig_now) begin
                    dev_next.trig_pend = 1'b1;
                end
            end
            default: begin
                dev_next.state = hmc_pkg::HMC_DS_IDLE;
            end
        endcase

        // Configuration is sampled at the start of every cycle
        if (start_cycle) begin
            dev_next.cfg       = chan_cfg_i;
            dev_next.short_rng = range_short_i;
            dev_next.chan      = `HMC_CH_X;
            dev_next.state     = hmc_pkg::HMC_DS_CONV;
            start_short        = range_short_i;
            tmr_start          = 1'b1;
        end

        // End-of-conversion pulse length
        if (!dev_reg.int_n) begin
            if (dev_reg.int_cnt <= `HMC_INT_W'(1)) begin
                dev_next.int_n = 1'b1;
            end else begin
                dev_next.int_cnt = dev_reg.int_cnt - `HMC_INT_W'(1);
            end
        end

        // Result readout in channel order, wrapping at the last channel
        if (link.rd_req) begin
            dev_next.rd_valid = 1'b1;
            dev_next.rd_data  = dev_reg.res[dev_reg.rd_ptr];
            dev_next.rd_chan  = dev_reg.rd_ptr;
            dev_next.rd_ptr   = (dev_reg.rd_ptr == last_chan(dev_reg.cfg)) ?
                                `HMC_CH_X : dev_reg.rd_ptr + 2'h1;
        end

        tmr_load = start_short ? `HMC_TMR_W'(CONV_SR_CYC) : `HMC_TMR_W'(CONV_FULL_CYC);
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dev_reg           <= '0;
            dev_reg.state     <= hmc_pkg::HMC_DS_IDLE;
            dev_reg.cfg       <= hmc_pkg::HMC_CFG_XYZT;
            dev_reg.int_n     <= 1'b1;
        end else begin
            dev_reg <= dev_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign link.int_n    = dev_reg.int_n;
    assign link.rd_valid = dev_reg.rd_valid;
    assign link.rd_data  = dev_reg.rd_data;
    assign link.rd_chan  = dev_reg.rd_chan;
    assign result_o      = dev_reg.res;
    assign busy_o        = (dev_reg.state == hmc_pkg::HMC_DS_CONV);
    assign cycle_done_o  = dev_reg.done;
    assign chan_o        = dev_reg.chan;
endmodule

// ---- rtl/hmc_host.sv ----
`timescale 1ns/1ps
`include "hmc_map.svh"
module hmc_host (
    input  wire logic                   ref_clk_i,
    input  wire logic                   resetn_i,
    hmc_link_if.host                    link,
    input  wire logic                   range_short_i,
    input  wire hmc_pkg::hmc_chcfg_e    chan_cfg_i,
    input  wire logic                   trig_req_i,
    output logic [`HMC_DATA_W-1:0]      result_o,
    output logic [1:0]                  result_chan_o,
    output logic                        result_valid_o,
    output logic                        frame_done_o,
    output logic                        reading_o
);
    typedef struct packed {
        hmc_pkg::hmc_host_state_e state;
        logic                     int_q;
        logic [2:0]               left;
        logic                     short_rng;
        logic                     trig;
        logic [`HMC_DATA_W-1:0]   res;
        logic [1:0]               chan;
        logic                     valid;
        logic                     done;
    } hmc_host_s;

    hmc_host_s             hst_reg;
    hmc_host_s             hst_next;
    logic                  tmr_start;
    logic [`HMC_TMR_W-1:0] tmr_load;
    logic                  tmr_done;
    logic                  int_rise;

    hmc_delay u_read_tmr (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .start_i   (tmr_start),
        .load_i    (tmr_load),
        .done_o    (tmr_done),
        .busy_o    ()
    );

    // ------------------------------------------------------------------------
    // Readout paced by the end-of-conversion edge
    // ------------------------------------------------------------------------
    always_comb begin
        hst_next       = hst_reg;
        hst_next.int_q = link.int_n;
        hst_next.trig  = trig_req_i;
        hst_next.valid = 1'b0;
        hst_next.done  = 1'b0;
        tmr_start      = 1'b0;
        tmr_load       = '0;
        link.rd_req    = 1'b0;
        int_rise       = link.int_n && !hst_reg.int_q;

        case (hst_reg.state)
            hmc_pkg::HMC_HS_WAIT: begin
                if (tmr_done) begin
                    hst_next.state = hmc_pkg::HMC_HS_READ;
                end
            end
            hmc_pkg::HMC_HS_READ: begin
                link.rd_req    = 1'b1;
                hst_next.state = hmc_pkg::HMC_HS_DATA;
            end
            hmc_pkg::HMC_HS_DATA: begin
                if (link.rd_valid) begin
                    hst_next.valid = 1'b1;
                    hst_next.res   = link.rd_data;
                    hst_next.chan  = link.rd_chan;
                    hst_next.left  = hst_reg.left - 3'h1;
                    if (hst_reg.left <= 3'h1) begin
                        hst_next.done  = 1'b1;
                        hst_next.state = hmc_pkg::HMC_HS_IDLE;
                    end else begin
                        tmr_start      = 1'b1;
                        tmr_load       = hst_reg.short_rng ?
                                         `HMC_TMR_W'(`HMC_RDN_SR_CYC) :
                                         `HMC_TMR_W'(`HMC_RDN_FULL_CYC);
                        hst_next.state = hmc_pkg::HMC_HS_WAIT;
                    end
                end
            end
            default: begin
                hst_next.state = hmc_pkg::HMC_HS_IDLE;
            end
        endcase

        // A fresh end-of-conversion restarts the readout
        if (int_rise) begin
            hst_next.short_rng = range_short_i;
            case (chan_cfg_i)
                hmc_pkg::HMC_CFG_XYZ: hst_next.left = 3'h3;
                hmc_pkg::HMC_CFG_XY:  hst_next.left = 3'h2;
                default:              hst_next.left = 3'h4;
            endcase
            tmr_start      = 1'b1;
            tmr_load       = range_short_i ? `HMC_TMR_W'(`HMC_RD1_SR_CYC) :
                                             `HMC_TMR_W'(`HMC_RD1_FULL_CYC);
            hst_next.state = hmc_pkg::HMC_HS_WAIT;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hst_reg       <= '0;
            hst_reg.state <= hmc_pkg::HMC_HS_IDLE;
            hst_reg.int_q <= 1'b1;
        end else begin
            hst_reg <= hst_next;
        end
    end

    assign link.trig      = hst_reg.trig;
    assign result_o       = hst_reg.res;
    assign result_chan_o  = hst_reg.chan;
    assign result_valid_o = hst_reg.valid;
    assign frame_done_o   = hst_reg.done;
    assign reading_o      = (hst_reg.state != hmc_pkg::HMC_HS_IDLE);
endmodule

// ---- verification/hmc_link_properties.sv ----
`timescale 1ns/1ps
module hmc_link_properties (
    input wire logic                 ref_clk_i,
    input wire logic                 resetn_i,
    input wire logic                 int_n,
    input wire logic                 trig,
    input wire logic                 rd_req,
    input wire logic                 rd_valid,
    input wire hmc_pkg::hmc_sample_t rd_data,
    input wire logic [1:0]           rd_chan
);
    logic [8:0]  low_cnt_reg;
    logic        int_q_reg;
    logic [11:0] rd1_cnt_reg;
    logic [11:0] rdn_cnt_reg;
    logic [11:0] ord_cnt_reg;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Counts clocks of the interrupt low phase
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_reg <= 9'h0;
        end else begin
            low_cnt_reg <= int_n ? 9'h0 : low_cnt_reg + 9'h1;
        end
    end

    // Clocks waited for the first read, the next read and channel one
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_q_reg   <= 1'b1;
            rd1_cnt_reg <= 12'h0;
            rdn_cnt_reg <= 12'h0;
            ord_cnt_reg <= 12'h0;
        end else begin
            int_q_reg   <= int_n;
            rd1_cnt_reg <= (int_n && !int_q_reg) ? 12'h1 : rd_req ? 12'h0 :
                           rd1_cnt_reg + {11'h0, rd1_cnt_reg != 12'h0};
            rdn_cnt_reg <= (rd_valid && rd_chan == 2'h0) ? 12'h1 : rd_req ? 12'h0 :
                           rdn_cnt_reg + {11'h0, rdn_cnt_reg != 12'h0};
            ord_cnt_reg <= (rd_valid && rd_chan == 2'h0) ? 12'h1 :
                           (rd_valid && rd_chan == 2'h1) ? 12'h0 :
                           ord_cnt_reg + {11'h0, ord_cnt_reg != 12'h0};
        end
    end

    a_int_pulse_len: assert property ($rose(int_n) |->
        low_cnt_reg >= 9'h0b4 && low_cnt_reg <= 9'h140)
        else $error("interrupt pulse length out of range");
    a_first_read_due: assert property (rd1_cnt_reg <= 12'hbb8)
        else $error("first read late");
    a_next_read_due: assert property (rdn_cnt_reg <= 12'hc80)
        else $error("next read late");
    a_chan_order: assert property (ord_cnt_reg <= 12'hce4)
        else $error("read channel order broken");
    a_read_answer: assert property (rd_req |=> rd_valid)
        else $error("read not answered");
    a_valid_cause: assert property (rd_valid |-> $past(rd_req))
        else $error("answer without request");
    a_data_hold: assert property (!rd_valid |-> $stable(rd_data) && $stable(rd_chan))
        else $error("read data changed without answer");
    a_trig_pulse: assert property (trig |=> !trig)
        else $error("trigger longer than one clock");

    c_int_pulse: cover property ($rose(int_n));
    c_temp_read: cover property (rd_valid && rd_chan == 2'h3);
    c_trig: cover property (trig ##1 !trig);
endmodule

// ---- verification/hall_measurement_cycle_readout_tb_top.sv ----
`timescale 1ns/1ps
module hall_measurement_cycle_readout_tb_top;
    logic                ref_clk_i;
    logic                resetn_i;
    hmc_pkg::hmc_mode_e  mode;
    hmc_pkg::hmc_chcfg_e cfg;
    logic                short_rng;
    logic                int_en;
    logic                lp_fast;
    logic                trig_req;
    logic [3:0][11:0]    samp;
    logic [3:0][11:0]    res;
    logic                busy;
    logic                cdone;
    logic [1:0]          chan;
    logic [11:0]         h_res;
    logic [1:0]          h_chan;
    logic                h_valid;
    logic                h_done;
    logic                h_reading;
    logic [11:0]         exp_res [4];
    int                  error_cnt;
    int                  n_compared;
    int                  cnt;

    hmc_link_if link ();

    hmc_device #(.CONV_FULL_CYC(20), .CONV_SR_CYC(20), .LP_SLOW_CYC(300), .LP_FAST_CYC(150))
    hmc_device_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link), .mode_i(mode),
        .chan_cfg_i(cfg), .range_short_i(short_rng), .int_en_i(int_en), .lp_rate_fast_i(lp_fast),
        .sample_i(samp), .result_o(res), .busy_o(busy), .cycle_done_o(cdone), .chan_o(chan));

    hmc_host hmc_host_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link),
        .range_short_i(short_rng), .chan_cfg_i(cfg), .trig_req_i(trig_req), .result_o(h_res),
        .result_chan_o(h_chan), .result_valid_o(h_valid), .frame_done_o(h_done),
        .reading_o(h_reading));

    hmc_link_properties hmc_link_properties_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .int_n(link.int_n), .trig(link.trig), .rd_req(link.rd_req), .rd_valid(link.rd_valid),
        .rd_data(link.rd_data), .rd_chan(link.rd_chan));

    // ------------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------------------
    task automatic count_done(input int ncyc, output int n);
        n = 0;
        repeat (ncyc) begin
            @(negedge ref_clk_i);
            if (cdone === 1'b1) n++;
        end
    endtask

    // One triggered cycle, then the host readout of it
    task automatic frame(input hmc_pkg::hmc_chcfg_e c, input logic s, input int n, input int r);
        int k;
        int t;
        @(negedge ref_clk_i);
        cfg = c;
        short_rng = s;
        for (k = 0; k < 4; k++) samp[k] = 12'(32'h100 * (k + 1) + r);
        trig_req = 1'b1;
        @(negedge ref_clk_i);
        trig_req = 1'b0;
        t = 0;
        while (cdone !== 1'b1 && t < 1000) begin
            @(negedge ref_clk_i);
            t++;
        end
        chk("cycle end", 12'h1, {11'h0, cdone});
        for (k = 0; k < 4; k++) begin
            if (k < n) exp_res[k] = samp[k];
            chk("device result", exp_res[k], res[k]);
        end
        k = 0;
        t = 0;
        while (t < 12000) begin
            @(negedge ref_clk_i);
            t++;
            if (h_valid === 1'b1 && k < 4) begin
                chk("host data", exp_res[k], h_res);
                chk("host channel", 12'(k), {10'h0, h_chan});
                chk("frame end", {11'h0, k == n - 1}, {11'h0, h_done});
                k++;
                if (h_done === 1'b1) t = 12000;
            end
        end
        chk("read count", 12'(n), 12'(k));
        chk("readout idle", 12'h0, {11'h0, h_reading});
    endtask

    // ------------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        #800000;
        error_cnt++;
        $display("unexpected watchdog: expected done, seen hang");
        end_of_test();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        resetn_i = 1'b0;
        mode = hmc_pkg::HMC_MASTER;
        cfg = hmc_pkg::HMC_CFG_XYZT;
        {short_rng, int_en, lp_fast, trig_req} = 4'h4;
        samp = '0;
        for (int i = 0; i < 4; i++) exp_res[i] = 12'h0;
        repeat (4) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        chk("idle interrupt", 12'h1, {11'h0, link.int_n});
        chk("idle busy", 12'h0, {11'h0, busy});
        chk("idle channel", 12'h0, {10'h0, chan});
        frame(hmc_pkg::HMC_CFG_XYZT, 1'b0, 4, 1);
        frame(hmc_pkg::HMC_CFG_XYZ, 1'b1, 3, 2);
        frame(hmc_pkg::HMC_CFG_XY, 1'b0, 2, 3);
        frame(hmc_pkg::HMC_CFG_XYZT, 1'b1, 4, 4);
        mode = hmc_pkg::HMC_POWER_DOWN;
        trig_req = 1'b1;
        @(negedge ref_clk_i);
        trig_req = 1'b0;
        count_done(200, cnt);
        chk("cycles without start", 12'h0, 12'(cnt));
        int_en = 1'b0;
        cfg = hmc_pkg::HMC_CFG_XY;
        mode = hmc_pkg::HMC_FAST;
        count_done(400, cnt);
        chk("continuous cycles", 12'h1, {11'h0, cnt >= 7});
        lp_fast = 1'b1;
        mode = hmc_pkg::HMC_LOW_POWER;
        count_done(100, cnt);
        count_done(1500, cnt);
        chk("fast update rate", 12'h1, {11'h0, cnt >= 9 && cnt <= 11});
        lp_fast = 1'b0;
        count_done(300, cnt);
        count_done(1500, cnt);
        chk("slow update rate", 12'h1, {11'h0, cnt >= 4 && cnt <= 6});
        end_of_test();
    end
endmodule
